// [line_defect_defines.svh]
// register map, field positions and reset values for the line defect inserter
// What this block does
// [RQ1] force bit 5 sends line defect
// [RQ2] defect sets K2 bits 6-8 to 110
// [RQ3] loss or alarm force masks force bit
// [RQ4] clearing force bit stops forced defect
// [RQ5] enable bit 2: line alarm triggers defect
// [RQ6] enable bit 1: frame loss triggers defect
// [RQ7] enable bit 0: signal loss triggers defect
// [RQ8] enable bits 0-2 reset to one
// [RQ9] idle: K2 bits 6-8 not 110
// [RQ10] error indication: auto, software, or external
// [RQ11] force and enabled causes are ORed
// [RQ12] idle K2 bits pass unchanged unless bits 6-8 are 110
`ifndef LINE_DEFECT_DEFINES_SVH
`define LINE_DEFECT_DEFINES_SVH

// register indices; byte address is four times the index
`define TXC0_INDEX 16'h1902
`define RDIC_INDEX 16'h1933
`define REIC_INDEX 16'h1934
`define STAT_INDEX 16'h1935
`define TXC0_ADDR {`TXC0_INDEX, 2'b00}
`define RDIC_ADDR {`RDIC_INDEX, 2'b00}
`define REIC_ADDR {`REIC_INDEX, 2'b00}
`define STAT_ADDR {`STAT_INDEX, 2'b00}

// transmit control byte 0 fields
`define TXC0_SIGNAL_LOSS_FORCE 3
`define TXC0_LINE_ALARM_FORCE 4
`define TXC0_LINE_DEFECT_FORCE 5
`define TXC0_ERROR_BYTE_SOURCE_SEL0 7
`define TXC0_WMASK 8'hBF
`define TXC0_RESET 8'h00

// automatic defect control fields
`define RDIC_ON_SIGNAL_LOSS 0
`define RDIC_ON_FRAME_LOSS 1
`define RDIC_ON_LINE_ALARM 2
`define RDIC_EXTERNAL_EN 3
`define RDIC_WMASK 8'h0F
`define RDIC_RESET 8'h07

// error indication control fields
`define REIC_SOURCE_SEL1 0
`define REIC_SW_LSB 4
`define REIC_WMASK 8'hF1
`define REIC_RESET 8'h00

// status fields
`define STAT_SIGNAL_LOSS 0
`define STAT_FRAME_LOSS 1
`define STAT_LINE_ALARM 2
`define STAT_DEFECT_ACTIVE 3
`define STAT_REI_LSB 4

// overhead byte fields
`define K2_DEFECT_PATTERN 3'h6
`define K2_FIELD_W 3
`define M0_FIELD_W 4
`define BYTE_ZERO 8'h00

`endif

// [line_defect_pkg.sv]
// types shared by the line defect inserter
`default_nettype none
package line_defect_pkg;
	// error indication source for the M0 field
	typedef enum logic [1:0] {
		REI_AUTO = 2'b00,
		REI_SOFTWARE = 2'b01,
		REI_EXTERNAL = 2'b10
	} rei_source_t;
endpackage
`default_nettype wire

// [line_defect_cause.sv]
// combines forced and automatic line defect causes
`default_nettype none
`include "line_defect_defines.svh"
module line_defect_cause (
	// control fields
	input wire logic [7:0] txc0,
	input wire logic [7:0] rdic,
	// receive side defects
	input wire logic rx_signal_loss,
	input wire logic rx_frame_loss,
	input wire logic rx_line_alarm,
	// result
	output logic defect_req
);
	logic force_ok;
	logic auto_req;

	// force honoured only while no loss or alarm force
	always_comb begin
		// [RQ3] force masked by overrides
		force_ok = txc0[`TXC0_LINE_DEFECT_FORCE]
			& ~txc0[`TXC0_SIGNAL_LOSS_FORCE]
			& ~txc0[`TXC0_LINE_ALARM_FORCE];
		// [RQ5] [RQ6] [RQ7] enabled automatic causes
		auto_req = (rdic[`RDIC_ON_LINE_ALARM] & rx_line_alarm)
			| (rdic[`RDIC_ON_FRAME_LOSS] & rx_frame_loss)
			| (rdic[`RDIC_ON_SIGNAL_LOSS] & rx_signal_loss);
		// [RQ11] OR of all causes
		defect_req = force_ok | auto_req;
	end
endmodule
`default_nettype wire

// [overhead_byte_insert.sv]
// writes K2 defect field and M0 error field into the outbound byte stream
`default_nettype none
`include "line_defect_defines.svh"
module overhead_byte_insert (
	// clock and reset
	input wire logic clock,
	input wire logic reset_n,
	// inbound stream
	input wire logic [7:0] byte_in,
	input wire logic byte_valid,
	input wire logic k2_slot,
	input wire logic m0_slot,
	// field values
	input wire logic defect_req,
	input wire logic [3:0] rei_value,
	// outbound stream
	output logic [7:0] byte_out_r,
	output logic valid_out_r,
	output logic defect_sent_r
);
	logic [7:0] byte_out_nxt;
	logic valid_out_nxt;
	logic defect_sent_nxt;

	// field substitution on overhead slots
	always_comb begin
		byte_out_nxt = byte_in;
		valid_out_nxt = byte_valid;
		defect_sent_nxt = defect_sent_r;
		if (byte_valid && k2_slot) begin
			defect_sent_nxt = defect_req;
			if (defect_req) begin
				// [RQ2] pattern in K2 bits 6-8
				byte_out_nxt = {byte_in[7:`K2_FIELD_W], `K2_DEFECT_PATTERN};
			end else if (byte_in[`K2_FIELD_W-1:0] == `K2_DEFECT_PATTERN) begin
				// [RQ9] never 110 when idle
				byte_out_nxt = {byte_in[7:`K2_FIELD_W], {`K2_FIELD_W{1'b0}}};
			end
			// [RQ12] otherwise byte passes unchanged
		end else if (byte_valid && m0_slot) begin
			// [RQ10] error field into M0 bits 5-8
			byte_out_nxt = {byte_in[7:`M0_FIELD_W], rei_value};
		end
	end

	// stream registers
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			byte_out_r <= `BYTE_ZERO;
			valid_out_r <= 1'b0;
			defect_sent_r <= 1'b0;
		end else begin
			byte_out_r <= byte_out_nxt;
			valid_out_r <= valid_out_nxt;
			defect_sent_r <= defect_sent_nxt;
		end
	end
endmodule
`default_nettype wire

// [line_defect_inserter.sv]
// line remote defect inserter: APB registers, cause combine, K2/M0 insertion
//
// Our own choice: the APB register port.
`default_nettype none
`include "line_defect_defines.svh"
module line_defect_inserter #(
	parameter int ADDR_W = 18
) (
	// clock and reset
	input wire logic clock,
	input wire logic reset_n,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// receive side defect indications
	input wire logic rx_signal_loss,
	input wire logic rx_frame_loss,
	input wire logic rx_line_alarm,
	input wire logic [3:0] rx_b2_error_count,
	// external error indication value
	input wire logic [3:0] path_overhead_input_port,
	// inbound transmit stream
	input wire logic [7:0] tx_byte_in,
	input wire logic tx_byte_valid,
	input wire logic tx_k2_slot,
	input wire logic tx_m0_slot,
	// outbound transmit stream
	output logic [7:0] tx_byte_out,
	output logic tx_byte_valid_out,
	output logic line_defect_sent
);
	// register state
	logic [7:0] txc0_r;
	logic [7:0] txc0_nxt;
	logic [7:0] rdic_r;
	logic [7:0] rdic_nxt;
	logic [7:0] reic_r;
	logic [7:0] reic_nxt;

	// bus answer state
	logic [31:0] prdata_r;
	logic [31:0] prdata_nxt;
	logic pready_r;
	logic pready_nxt;
	logic pslverr_r;
	logic pslverr_nxt;

	// decode
	logic sel_txc0;
	logic sel_rdic;
	logic sel_reic;
	logic sel_stat;
	logic mapped;
	logic setup_phase;
	logic write_take;

	// datapath
	logic defect_req;
	logic [3:0] rei_value;
	logic [7:0] status_byte;
	line_defect_pkg::rei_source_t rei_source;

	// address decode of the four registers
	always_comb begin
		sel_txc0 = (paddr == ADDR_W'(`TXC0_ADDR));
		sel_rdic = (paddr == ADDR_W'(`RDIC_ADDR));
		sel_reic = (paddr == ADDR_W'(`REIC_ADDR));
		sel_stat = (paddr == ADDR_W'(`STAT_ADDR));
		mapped = sel_txc0 | sel_rdic | sel_reic | sel_stat;
		setup_phase = psel & ~penable;
		write_take = psel & penable & pready_r & pwrite & ~pslverr_r & pstrb[0];
	end

	// error indication source choice
	always_comb begin
		if (reic_r[`REIC_SOURCE_SEL1]) begin
			rei_source = line_defect_pkg::REI_EXTERNAL;
		end else if (txc0_r[`TXC0_ERROR_BYTE_SOURCE_SEL0]) begin
			rei_source = line_defect_pkg::REI_SOFTWARE;
		end else begin
			rei_source = line_defect_pkg::REI_AUTO;
		end
	end

	// [RQ10] error indication value per source
	always_comb begin
		case (rei_source)
			line_defect_pkg::REI_AUTO: begin
				rei_value = rx_b2_error_count;
			end
			line_defect_pkg::REI_SOFTWARE: begin
				rei_value = reic_r[`REIC_SW_LSB +: `M0_FIELD_W];
			end
			line_defect_pkg::REI_EXTERNAL: begin
				rei_value = path_overhead_input_port;
			end
			default: begin
				rei_value = rx_b2_error_count;
			end
		endcase
	end

	// live status byte
	always_comb begin
		status_byte = `BYTE_ZERO;
		status_byte[`STAT_SIGNAL_LOSS] = rx_signal_loss;
		status_byte[`STAT_FRAME_LOSS] = rx_frame_loss;
		status_byte[`STAT_LINE_ALARM] = rx_line_alarm;
		status_byte[`STAT_DEFECT_ACTIVE] = defect_req;
		status_byte[`STAT_REI_LSB +: `M0_FIELD_W] = rei_value;
	end

	// register writes, masked to writable bits
	always_comb begin
		txc0_nxt = txc0_r;
		rdic_nxt = rdic_r;
		reic_nxt = reic_r;
		if (write_take) begin
			if (sel_txc0) begin
				// [RQ1] [RQ4] force bit set and cleared by software
				txc0_nxt = pwdata[7:0] & `TXC0_WMASK;
			end
			if (sel_rdic) begin
				// [RQ8] automatic enables live in low bits
				rdic_nxt = pwdata[7:0] & `RDIC_WMASK;
			end
			if (sel_reic) begin
				reic_nxt = pwdata[7:0] & `REIC_WMASK;
			end
		end
	end

	// control registers
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			txc0_r <= `TXC0_RESET;
			// [RQ8] enables reset to one
			rdic_r <= `RDIC_RESET;
			reic_r <= `REIC_RESET;
		end else begin
			txc0_r <= txc0_nxt;
			rdic_r <= rdic_nxt;
			reic_r <= reic_nxt;
		end
	end

	// answer prepared in setup, shown during access
	always_comb begin
		prdata_nxt = prdata_r;
		pready_nxt = 1'b0;
		pslverr_nxt = 1'b0;
		if (setup_phase) begin
			pready_nxt = 1'b1;
			pslverr_nxt = ~mapped;
			prdata_nxt = 32'h0000_0000;
			if (!pwrite) begin
				if (sel_txc0) begin
					prdata_nxt[7:0] = txc0_r;
				end else if (sel_rdic) begin
					prdata_nxt[7:0] = rdic_r;
				end else if (sel_reic) begin
					prdata_nxt[7:0] = reic_r;
				end else if (sel_stat) begin
					prdata_nxt[7:0] = status_byte;
				end
			end
		end
	end

	// bus answer registers
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			prdata_r <= 32'h0000_0000;
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
		end else begin
			prdata_r <= prdata_nxt;
			pready_r <= pready_nxt;
			pslverr_r <= pslverr_nxt;
		end
	end

	// bus outputs straight from flip-flops
	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;

	// forced and automatic causes
	line_defect_cause u_cause (
		.txc0(txc0_r),
		.rdic(rdic_r),
		.rx_signal_loss(rx_signal_loss),
		.rx_frame_loss(rx_frame_loss),
		.rx_line_alarm(rx_line_alarm),
		.defect_req(defect_req)
	);

	// [RQ2] [RQ11] applied at each K2 byte
	overhead_byte_insert u_insert (
		.clock(clock),
		.reset_n(reset_n),
		.byte_in(tx_byte_in),
		.byte_valid(tx_byte_valid),
		.k2_slot(tx_k2_slot),
		.m0_slot(tx_m0_slot),
		.defect_req(defect_req),
		.rei_value(rei_value),
		.byte_out_r(tx_byte_out),
		.valid_out_r(tx_byte_valid_out),
		.defect_sent_r(line_defect_sent)
	);
endmodule
`default_nettype wire

// [remote_lte_rx.sv]
// far end receiver model: keeps the K2 defect field of each frame
`default_nettype none
module remote_lte_rx (
	// clock and reset
	input wire logic clock,
	input wire logic reset_n,
	// line from the inserter
	input wire logic k2_slot,
	input wire logic [7:0] line_byte,
	input wire logic line_valid,
	// decoded defect field
	output logic [2:0] field_r
);
	timeunit 1ns;
	timeprecision 1ps;
	logic k2_r;
	logic [2:0] field_nxt;
	// the byte after a k2 slot carries the field
	always_comb begin
		field_nxt = field_r;
		if (k2_r && line_valid) field_nxt = line_byte[2:0];
	end
	// state registers
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			k2_r <= 1'b0;
			field_r <= 3'h0;
		end else begin
			k2_r <= k2_slot;
			field_r <= field_nxt;
		end
	end
endmodule
`default_nettype wire

// [line_defect_props.sv]
// checker: defect field insertion and bus timing
`default_nettype none
`include "line_defect_defines.svh"
module line_defect_props #(
	parameter int ADDR_W = 18
) (
	// clock and reset
	input wire logic clock,
	input wire logic reset_n,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic pready,
	input wire logic pslverr,
	// receiver defects
	input wire logic rx_signal_loss,
	input wire logic rx_frame_loss,
	input wire logic rx_line_alarm,
	// stream
	input wire logic [7:0] tx_byte_in,
	input wire logic tx_byte_valid,
	input wire logic tx_k2_slot,
	input wire logic [7:0] tx_byte_out,
	input wire logic tx_byte_valid_out,
	input wire logic line_defect_sent
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [5:0] shadow_r;
	logic [5:0] shadow_nxt;
	logic auto_c;
	logic req;
	// shadow of force bits 5:3 and enables 2:0 from completed writes
	always_comb begin
		shadow_nxt = shadow_r;
		if (psel && penable && pready && pwrite && !pslverr && pstrb[0]) begin
			if (paddr == `TXC0_ADDR) shadow_nxt[5:3] = pwdata[5:3];
			if (paddr == `RDIC_ADDR) shadow_nxt[2:0] = pwdata[2:0];
		end
	end
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) shadow_r <= 6'h07;
		else shadow_r <= shadow_nxt;
	end
	// expected request
	assign auto_c = |(shadow_r[2:0] & {rx_line_alarm, rx_frame_loss, rx_signal_loss});
	assign req = (shadow_r[5] && !shadow_r[4] && !shadow_r[3]) || auto_c;
	default clocking @(posedge clock); endclocking
	default disable iff (!reset_n);
	sequence k2_s; tx_byte_valid && tx_k2_slot; endsequence
	sequence setup_s; psel && !penable; endsequence
	// answer one cycle after setup
	pready_follow_a: assert property (setup_s |=> pready)
		else $error("no ready after setup");
	// valid flag latency one cycle
	valid_lat_a: assert property (1'b1 |=> tx_byte_valid_out == $past(tx_byte_valid))
		else $error("valid latency wrong");
	set_pattern_a: assert property (k2_s ##0 req |=> tx_byte_out[2:0] == 3'h6 && line_defect_sent)
		else $error("defect pattern missing");
	idle_field_a: assert property (k2_s ##0 !req |=> tx_byte_out[2:0] != 3'h6)
		else $error("idle field shows defect");
	idle_pass_a: assert property (k2_s ##0 !req && tx_byte_in[2:0] != 3'h6 |=>
		tx_byte_out == $past(tx_byte_in)) else $error("idle k2 altered");
	masked_force_a: assert property (k2_s ##0 shadow_r[5] && |shadow_r[4:3] && !auto_c
		|=> !line_defect_sent) else $error("masked force still sent");
	k2_upper_a: assert property (k2_s |=> ((tx_byte_out ^ $past(tx_byte_in)) & 8'hF8) == 8'h00)
		else $error("k2 upper bits altered");
	// sent flag moves only at k2
	sent_hold_a: assert property (!(tx_byte_valid && tx_k2_slot) |=> $stable(line_defect_sent))
		else $error("sent flag moved");
endmodule
bind line_defect_inserter line_defect_props #(.ADDR_W(ADDR_W)) props (.clock, .reset_n, .psel,
	.penable, .pwrite, .paddr, .pwdata, .pstrb, .pready, .pslverr, .rx_signal_loss, .rx_frame_loss,
	.rx_line_alarm, .tx_byte_in, .tx_byte_valid, .tx_k2_slot, .tx_byte_out, .tx_byte_valid_out,
	.line_defect_sent);
`default_nettype wire

// [tb.sv]
// self-checking bench for the line defect inserter
`default_nettype none
`include "line_defect_defines.svh"
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {
		logic [7:0] ctl;
		logic [7:0] en;
		logic [2:0] rx;
		logic [7:0] din;
		logic [7:0] dout;
	} row_t;
	logic clock = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic rx_signal_loss = 1'b0, rx_frame_loss = 1'b0, rx_line_alarm = 1'b0;
	logic tx_byte_valid = 1'b0, tx_k2_slot = 1'b0, tx_m0_slot = 1'b0;
	logic [17:0] paddr = 18'h00000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic [3:0] path_overhead_input_port = 4'h0;
	logic [3:0] rx_b2_error_count = 4'h0;
	logic [7:0] tx_byte_in = 8'h00, tx_byte_out;
	logic [2:0] field;
	logic pready, pslverr, er, tx_byte_valid_out, line_defect_sent;
	int error_cnt = 0;
	int samples_checked = 0;
	// rx order is line alarm, frame loss, signal loss
	row_t rows [12] = '{'{8'h20, 8'h00, 3'h0, 8'h00, 8'h06}, '{8'h28, 8'h00, 3'h0, 8'h00, 8'h00},
		'{8'h30, 8'h00, 3'h0, 8'h00, 8'h00}, '{8'h00, 8'h00, 3'h0, 8'hF6, 8'hF0},
		'{8'h00, 8'h04, 3'h4, 8'h00, 8'h06}, '{8'h00, 8'h03, 3'h4, 8'h00, 8'h00},
		'{8'h00, 8'h02, 3'h2, 8'h00, 8'h06}, '{8'h00, 8'h05, 3'h2, 8'h00, 8'h00},
		'{8'h00, 8'h01, 3'h1, 8'h00, 8'h06}, '{8'h00, 8'h06, 3'h1, 8'h00, 8'h00},
		'{8'h00, 8'h07, 3'h0, 8'hA5, 8'hA5}, '{8'h28, 8'h01, 3'h1, 8'h18, 8'h1E}};
	line_defect_inserter uut (.clock, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata,
		.pstrb(4'hF), .prdata, .pready, .pslverr, .rx_signal_loss, .rx_frame_loss, .rx_line_alarm,
		.rx_b2_error_count, .path_overhead_input_port, .tx_byte_in, .tx_byte_valid,
		.tx_k2_slot, .tx_m0_slot, .tx_byte_out, .tx_byte_valid_out, .line_defect_sent);
	remote_lte_rx far (.clock, .reset_n, .k2_slot(tx_k2_slot), .line_byte(tx_byte_out),
		.line_valid(tx_byte_valid_out), .field_r(field));
	// clock
	always #25 clock = ~clock;
	task chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// one apb transfer, held until ready
	task apb(input logic w, input logic [17:0] a, input logic [31:0] d);
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		do @(posedge clock); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// one k2 or m0 byte, outputs settled on return
	task send(input logic m0, input logic [7:0] d);
		@(posedge clock);
		tx_byte_valid <= 1'b1;
		tx_k2_slot <= !m0;
		tx_m0_slot <= m0;
		tx_byte_in <= d;
		@(posedge clock);
		tx_byte_valid <= 1'b0;
		tx_k2_slot <= 1'b0;
		tx_m0_slot <= 1'b0;
		#1;
	endtask
	task stop_test();
		$display("checked %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// watchdog
	initial begin
		repeat (20000) @(posedge clock);
		error_cnt++;
		stop_test();
	end
	// main sequence
	initial begin
		repeat (5) @(posedge clock);
		reset_n <= 1'b1;
		for (int i = 0; i < 12; i++) begin
			apb(1'b1, `TXC0_ADDR, {24'h0, rows[i].ctl});
			apb(1'b1, `RDIC_ADDR, {24'h0, rows[i].en});
			{rx_line_alarm, rx_frame_loss, rx_signal_loss} <= rows[i].rx;
			send(1'b0, rows[i].din);
			chk(32'(tx_byte_out), 32'(rows[i].dout));
			chk(32'(tx_byte_valid_out), 32'h1);
			chk(32'(line_defect_sent), 32'(rows[i].dout[2:0] == 3'h6));
			@(posedge clock);
			#1;
			chk(32'(field), 32'(rows[i].dout[2:0]));
			$display("row %0d done", i);
		end
		// second reset mid-run, then reset values
		reset_n <= 1'b0;
		repeat (5) @(posedge clock);
		reset_n <= 1'b1;
		apb(1'b0, `RDIC_ADDR, 32'h0);
		chk(rd, 32'h7);
		apb(1'b0, `TXC0_ADDR, 32'h0);
		chk(rd, 32'h0);
		apb(1'b1, `RDIC_ADDR, 32'hFF);
		apb(1'b0, `RDIC_ADDR, 32'h0);
		chk(rd, 32'h0F);
		apb(1'b0, 18'h00010, 32'h0);
		chk({31'h0, er}, 32'h1);
		$display("register test done");
		// automatic, software and external error values into m0
		rx_b2_error_count <= 4'h5;
		send(1'b1, 8'hA0);
		chk(32'(tx_byte_out), 32'hA5);
		apb(1'b1, `TXC0_ADDR, 32'h80);
		apb(1'b1, `REIC_ADDR, 32'h30);
		send(1'b1, 8'hC0);
		chk(32'(tx_byte_out), 32'hC3);
		apb(1'b1, `REIC_ADDR, 32'h01);
		path_overhead_input_port <= 4'h9;
		send(1'b1, 8'hF0);
		chk(32'(tx_byte_out), 32'hF9);
		// live status: signal loss enabled, request active, external value
		apb(1'b0, `STAT_ADDR, 32'h0);
		chk(rd, 32'h99);
		$display("m0 test done");
		stop_test();
	end
endmodule
`default_nettype wire
